// ==== rtl/p3dc_cfg.svh ====
// Purpose: constants for the phase-3 diagnostic configuration slice
// Assumes: 16-bit register words, word addresses on the register port
// Notes:   times in ns, cycle counts derived from the 100 ns clock
`ifndef P3DC_CFG_SVH
`define P3DC_CFG_SVH

`define P3DC_ADDR_W            6
`define P3DC_DATA_W            16
`define P3DC_OFS_RESULT        6'h31
`define P3DC_OFS_CONFIG        6'h32
`define P3DC_RESULT_W          15
`define P3DC_CONFIG_RST        16'h0000
`define P3DC_RESULT_RST        15'h0000
`define P3DC_POS_OFFSEL        9
`define P3DC_POS_ONOFF         8
`define P3DC_POS_MASK_LSB      7
`define P3DC_POS_MASK_HSG      6
`define P3DC_POS_MASK_GOV      4
`define P3DC_POS_GTIME         2
`define P3DC_POS_CTIME         0
`define P3DC_CLK_PERIOD_NS     100
`define P3DC_T0_NS             200
`define P3DC_T1_NS             500
`define P3DC_T2_NS             1000
`define P3DC_T3_NS             1500
// least times round up to whole cycles
`define P3DC_CYC(t)            (((t) + `P3DC_CLK_PERIOD_NS - 1) / `P3DC_CLK_PERIOD_NS)

`endif

// ==== rtl/p3dc_pkg.sv ====
// Purpose: types for the phase-3 diagnostic configuration slice
// Assumes: nothing beyond the constants header
// Notes:   field layout follows the configuration word
package p3dc_pkg;

  typedef enum logic [1:0] {
    P3DC_OFF_NONE  = 2'b00,
    P3DC_OFF_PU    = 2'b01,
    P3DC_OFF_PD    = 2'b10,
    P3DC_OFF_NONE2 = 2'b11
  } p3dc_offsel_t;

  typedef struct packed {
    logic [4:0]   spare;
    p3dc_offsel_t offstate_check_select;
    logic         onstate_check_off;
    logic         low_short_batt_route_mask;
    logic         high_short_gnd_route_mask;
    logic         spare5;
    logic         gate_overlap_route_mask;
    logic [1:0]   gate_overlap_detect_time;
    logic [1:0]   command_overlap_detect_time;
  } p3dc_config_t;

  typedef struct packed {
    logic low_short_batt;
    logic high_short_gnd;
    logic gate_overlap;
  } p3dc_faults_t;

endpackage : p3dc_pkg

// ==== rtl/p3dc_regs.sv ====
// Purpose: phase-3 current result and diagnostic configuration registers
// Assumes: register port is word addressed, one-cycle write strobe, sync inputs
// Notes:   read data registered, one cycle after the read strobe
`include "p3dc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module p3dc_regs
  import p3dc_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [`P3DC_ADDR_W-1:0]     reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [`P3DC_DATA_W-1:0]     reg_wdata,
  output logic      [`P3DC_DATA_W-1:0]     reg_rdata,
  input  wire logic                        meas_valid,
  input  wire logic [`P3DC_RESULT_W-1:0]   meas_value,
  input  wire p3dc_faults_t                fault_in,
  output p3dc_faults_t                     fault_routed,
  output logic                             pullup_en,
  output logic                             pulldown_en,
  output logic                             onstate_check_en,
  output logic      [7:0]                  gate_overlap_cycles,
  output logic      [7:0]                  command_overlap_cycles
);

  localparam logic [7:0] C0 = 8'(`P3DC_CYC(`P3DC_T0_NS));
  localparam logic [7:0] C1 = 8'(`P3DC_CYC(`P3DC_T1_NS));
  localparam logic [7:0] C2 = 8'(`P3DC_CYC(`P3DC_T2_NS));
  localparam logic [7:0] C3 = 8'(`P3DC_CYC(`P3DC_T3_NS));

  p3dc_config_t              config_reg;
  logic [`P3DC_RESULT_W-1:0] current_value_reg;
  logic [2:0]                route_mask;

  // time code decode, shared by both overlap detectors
  function automatic logic [7:0] p3dc_time_cycles(input logic [1:0] code);
    unique case (code)
      2'b00:   p3dc_time_cycles = C0;
      2'b01:   p3dc_time_cycles = C1;
      2'b10:   p3dc_time_cycles = C2;
      2'b11:   p3dc_time_cycles = C3;
    endcase
  endfunction : p3dc_time_cycles

  //////////////////////////////////////////////////////////////////////////////
  // result capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      current_value_reg <= `P3DC_RESULT_RST;
    end else if (meas_valid) begin
      current_value_reg <= meas_value;
    end
  end

  // config write; whole word stored, spare bits inert
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      config_reg <= p3dc_config_t'(`P3DC_CONFIG_RST);
    end else if (reg_wr && reg_addr == `P3DC_OFS_CONFIG) begin
      config_reg <= p3dc_config_t'(reg_wdata);
    end
  end

  // read path; unmapped addresses read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `P3DC_OFS_RESULT: reg_rdata <= {1'b0, current_value_reg};
        `P3DC_OFS_CONFIG: reg_rdata <= config_reg;
        default:          reg_rdata <= '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // off-state current select
  assign pullup_en   = config_reg.offstate_check_select == P3DC_OFF_PU;
  assign pulldown_en = config_reg.offstate_check_select == P3DC_OFF_PD;
  assign onstate_check_en = !config_reg.onstate_check_off;
  // fault routing masks, one means masked
  // masks gathered in fault struct order so one loop serves all three
  assign route_mask = {config_reg.low_short_batt_route_mask,
                       config_reg.high_short_gnd_route_mask,
                       config_reg.gate_overlap_route_mask};
  for (genvar g = 0; g < 3; g++) begin : g_route
    assign fault_routed[g] = fault_in[g] & !route_mask[g];
  end
  assign gate_overlap_cycles    = p3dc_time_cycles(config_reg.gate_overlap_detect_time);
  assign command_overlap_cycles = p3dc_time_cycles(config_reg.command_overlap_detect_time);

  //////////////////////////////////////////////////////////////////////////////
  sequence s_cfg_write;
    reg_wr && reg_addr == `P3DC_OFS_CONFIG;
  endsequence

  sequence s_result_read;
    reg_rd && reg_addr == `P3DC_OFS_RESULT;
  endsequence

  sequence s_config_read;
    reg_rd && reg_addr == `P3DC_OFS_CONFIG;
  endsequence

  chk_result_top_zero: assert property (@(posedge clock) disable iff (!rst_n)
    $past(reg_rd) && $past(reg_addr) == `P3DC_OFS_RESULT |-> reg_rdata[15] == 1'b0)
    else $error("result top bit not zero");
  chk_offsel_exclusive: assert property (@(posedge clock) disable iff (!rst_n)
    s_cfg_write |=> pullup_en == ($past(reg_wdata[10:9]) == 2'b01) && !(pullup_en && pulldown_en))
    else $error("off-state select wrong");
  chk_pulldown_sel: assert property (@(posedge clock) disable iff (!rst_n)
    pulldown_en |-> config_reg[10:9] == 2'b10 && !pullup_en)
    else $error("pull-down enabled on wrong code");
  chk_onstate_off: assert property (@(posedge clock) disable iff (!rst_n)
    s_cfg_write ##1 1'b1 |-> onstate_check_en == !$past(reg_wdata[8]))
    else $error("on-state gate wrong");
  chk_mask_route: assert property (@(posedge clock) disable iff (!rst_n)
    fault_in.low_short_batt && !config_reg[7] |-> fault_routed.low_short_batt)
    else $error("low short fault not routed");
  chk_mask_block: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[6] || config_reg[4] |-> !(config_reg[6] && fault_routed.high_short_gnd)
      && !(config_reg[4] && fault_routed.gate_overlap))
    else $error("masked fault routed");
  chk_gate_time: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[3:2] == 2'b11 |-> gate_overlap_cycles == 8'h0F)
    else $error("gate overlap time wrong");
  chk_cmd_time: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[1:0] == 2'b00 |-> command_overlap_cycles == 8'h02)
    else $error("command overlap time wrong");
  chk_result_write: assert property (@(posedge clock) disable iff (!rst_n)
    reg_wr && reg_addr == `P3DC_OFS_RESULT && !meas_valid |=> $stable(current_value_reg) && $stable(config_reg))
    else $error("result write took effect");

  //////////////////////////////////////////////////////////////////////////////
  // reset values and the read path
  chk_reset_clear: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> current_value_reg == `P3DC_RESULT_RST && reg_rdata == 16'h0000
      && config_reg == p3dc_config_t'(`P3DC_CONFIG_RST))
    else $error("state not cleared by reset");
  chk_result_read: assert property (@(posedge clock) disable iff (!rst_n)
    s_result_read |=> reg_rdata == {1'b0, $past(current_value_reg)})
    else $error("result read data wrong");
  chk_config_read: assert property (@(posedge clock) disable iff (!rst_n)
    s_config_read |=> reg_rdata == $past(config_reg))
    else $error("config read data wrong");
  // read data must not drift between reads
  chk_rdata_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  //////////////////////////////////////////////////////////////////////////////
  // result capture and hold
  chk_result_load: assert property (@(posedge clock) disable iff (!rst_n)
    meas_valid |=> current_value_reg == $past(meas_value))
    else $error("measurement not captured");
  chk_result_keep: assert property (@(posedge clock) disable iff (!rst_n)
    !meas_valid |=> $stable(current_value_reg))
    else $error("result changed without a measurement");

  //////////////////////////////////////////////////////////////////////////////
  // config word stored whole, changed only by its own write
  chk_config_write: assert property (@(posedge clock) disable iff (!rst_n)
    s_cfg_write |=> config_reg == $past(reg_wdata))
    else $error("config write not stored");
  chk_config_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !(reg_wr && reg_addr == `P3DC_OFS_CONFIG) |=> $stable(config_reg))
    else $error("config changed without a write");

  //////////////////////////////////////////////////////////////////////////////
  // both currents off for the two idle codes
  chk_pullup_sel: assert property (@(posedge clock) disable iff (!rst_n)
    pullup_en |-> config_reg[10:9] == 2'b01 && !pulldown_en)
    else $error("pull-up enabled on wrong code");
  chk_offsel_idle: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[10] == config_reg[9] |-> !pullup_en && !pulldown_en)
    else $error("current enabled on idle code");
  chk_onstate_level: assert property (@(posedge clock) disable iff (!rst_n)
    onstate_check_en == !config_reg[8])
    else $error("on-state gate does not follow its bit");

  //////////////////////////////////////////////////////////////////////////////
  // remaining gate and command time codes
  chk_gate_code0: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[3:2] == 2'b00 |-> gate_overlap_cycles == 8'h02)
    else $error("gate overlap time wrong for code 0");
  chk_gate_code1: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[3:2] == 2'b01 |-> gate_overlap_cycles == 8'h05)
    else $error("gate overlap time wrong for code 1");
  chk_gate_code2: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[3:2] == 2'b10 |-> gate_overlap_cycles == 8'h0A)
    else $error("gate overlap time wrong for code 2");

  chk_cmd_code1: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[1:0] == 2'b01 |-> command_overlap_cycles == 8'h05)
    else $error("command overlap time wrong for code 1");
  chk_cmd_code2: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[1:0] == 2'b10 |-> command_overlap_cycles == 8'h0A)
    else $error("command overlap time wrong for code 2");
  chk_cmd_code3: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[1:0] == 2'b11 |-> command_overlap_cycles == 8'h0F)
    else $error("command overlap time wrong for code 3");

  //////////////////////////////////////////////////////////////////////////////
  // every fault routed when unmasked, none invented
  chk_route_high: assert property (@(posedge clock) disable iff (!rst_n)
    fault_in.high_short_gnd && !config_reg[6] |-> fault_routed.high_short_gnd)
    else $error("high short fault not routed");
  chk_route_gate: assert property (@(posedge clock) disable iff (!rst_n)
    fault_in.gate_overlap && !config_reg[4] |-> fault_routed.gate_overlap)
    else $error("gate overlap fault not routed");
  chk_mask_low: assert property (@(posedge clock) disable iff (!rst_n)
    config_reg[7] |-> !fault_routed.low_short_batt)
    else $error("masked low short fault routed");
  chk_route_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (fault_routed & ~fault_in) == 3'b000)
    else $error("routed fault without a raw fault");

endmodule : p3dc_regs

// ==== sim/p3dc_host.sv ====
// Purpose: host model on the register port
// Assumes: one-cycle strobes, moved 1 ns after the edge
// Notes:   idle address and data parked inverted
`include "p3dc_cfg.svh"
module p3dc_host (
  input  wire logic        clock,
  output logic [5:0]       reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic go(input logic [5:0] a, input logic [15:0] d, input logic w);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(posedge clock);
    #1;
  endtask : go
endmodule : p3dc_host

// ==== sim/phase3_diag_config_regs_bench.sv ====
// Purpose: self-checking bench for the phase-3 slice
// Assumes: host model drives the register port
// Notes:   expectations come from the field layout
`include "p3dc_cfg.svh"
module phase3_diag_config_regs_bench
  import p3dc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock, rst_n, reg_wr, reg_rd, meas_valid, pullup_en, pulldown_en, onstate_check_en;
  logic [5:0]   reg_addr;
  logic [15:0]  reg_wdata, reg_rdata;
  logic [14:0]  meas_value;
  p3dc_faults_t fault_in, fault_routed;
  logic [7:0]   gate_overlap_cycles, command_overlap_cycles;
  int           n_mismatch, checks_done;
  p3dc_regs p3dc_regs_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
    .meas_value(meas_value), .fault_in(fault_in), .fault_routed(fault_routed),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en), .onstate_check_en(onstate_check_en),
    .gate_overlap_cycles(gate_overlap_cycles), .command_overlap_cycles(command_overlap_cycles));
  p3dc_host p3dc_host_inst (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic t_read(input logic [5:0] a, input logic [15:0] exp);
    p3dc_host_inst.go(a, 16'h0000, 1'b0);
    check(reg_rdata, exp);
  endtask : t_read
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mode;
    for (int i = 0; i < 4; i++) begin
      p3dc_host_inst.go(6'h32, 16'(i) << 9, 1'b1);
      check({pullup_en, pulldown_en, onstate_check_en}, {i == 1, i == 2, 1'b1});
    end
    p3dc_host_inst.go(6'h32, 16'h0100, 1'b1);
    check(onstate_check_en, 1'b0);
  endtask : t_mode
  task automatic t_times;
    logic [7:0] cyc [4] = '{8'h02, 8'h05, 8'h0A, 8'h0F};
    for (int i = 0; i < 4; i++) begin
      p3dc_host_inst.go(6'h32, 16'((i << 2) | (3 - i)), 1'b1);
      check({gate_overlap_cycles, command_overlap_cycles}, {cyc[i], cyc[3 - i]});
    end
  endtask : t_times
  task automatic t_mask;
    fault_in = 3'b111;
    for (int i = 0; i < 3; i++) begin
      p3dc_host_inst.go(6'h32, 16'h0001 << ((i == 2) ? 4 : 7 - i), 1'b1);
      check(fault_routed, 3'b111 ^ (3'b100 >> i));
    end
  endtask : t_mask
  // result is read-only; spare bits store only
  task automatic t_result;
    @(posedge clock);
    #1;
    meas_value = 15'h7FFF;
    meas_valid = 1'b1;
    @(posedge clock);
    #1;
    meas_valid = 1'b0;
    t_read(6'h31, 16'h7FFF);
    p3dc_host_inst.go(6'h31, 16'h8000, 1'b1);
    t_read(6'h31, 16'h7FFF);
    p3dc_host_inst.go(6'h32, 16'hF820, 1'b1);
    t_read(6'h32, 16'hF820);
    check({pullup_en, pulldown_en, onstate_check_en, fault_routed}, 6'h0F);
    t_read(6'h3F, 16'h0000);
  endtask : t_result
  // reset in mid-run clears a loaded result and a full config word
  task automatic t_reset;
    p3dc_host_inst.go(6'h32, 16'hFFFF, 1'b1);
    check({pullup_en, pulldown_en, onstate_check_en, fault_routed}, 6'h00);
    check({gate_overlap_cycles, command_overlap_cycles}, 16'h0F0F);
    @(posedge clock);
    #1;
    meas_value = 15'h1234;
    meas_valid = 1'b1;
    @(posedge clock);
    #1;
    meas_valid = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check({pullup_en, pulldown_en, onstate_check_en, fault_routed}, 6'h0F);
    check({gate_overlap_cycles, command_overlap_cycles}, 16'h0202);
    t_read(6'h31, 16'h0000);
    t_read(6'h32, 16'h0000);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    meas_valid = 1'b0;
    meas_value = 15'h0000;
    fault_in = 3'b000;
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_read(6'h31, 16'h0000);
    t_read(6'h32, 16'h0000);
    t_mode();
    t_times();
    t_mask();
    t_result();
    t_reset();
    stop_test();
  end
endmodule : phase3_diag_config_regs_bench
